// ===== verilog/tcr_regs.sv
// 16-bit timer capture, compare, flag and mask registers with shared high-byte latch
`timescale 1ns/1ps

// Function
// - Capture event copies counter into capture value
// - Capture value may serve as counter TOP
// - Capture read atomic via shared temp byte
// - Compare writes atomic via shared temp byte
// - Compare values continuously matched against counter
// - Capture request needs mask5, global, flag
// - Compare B request needs mask2, global, flag
// - Compare A request needs mask1, global, flag
// - Overflow request needs mask0, global, flag
// - Capture flag on event, or TOP
// - Flags clear on vector or written one
// - Compare A flag one timer clock later
// - Compare B flag one timer clock later
// - Forced compare never sets a flag
// - Overflow flag set on engine overflow
// - Flags at data 0x36, I/O 0x16
// - Counter bytes atomic through temp byte
// - Counter write blocks next compare match
module tcr_regs (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // CPU byte register port
    input  wire logic [7:0]  cpu_addr,
    input  wire logic        cpu_io_space,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    // Interrupt controller
    input  wire logic        global_irq_en,
    input  wire logic [3:0]  irq_ack,
    output logic      [3:0]  irq_req,
    // Counting engine
    input  wire logic        tmr_tick,
    input  wire logic [15:0] timer1_count,
    input  wire logic [3:0]  waveform_mode_field,
    input  wire logic        top_reached,
    input  wire logic        overflow_evt,
    output logic             count_load,
    output logic      [15:0] count_load_value,
    output logic             capture_is_top,
    // Capture sources
    input  wire logic        capture_input_pin,
    input  wire logic        comparator_evt,
    input  wire logic        capture_src_sel,
    // Compare values and waveform matches
    input  wire logic        force_match_a,
    input  wire logic        force_match_b,
    output logic      [15:0] capture_value,
    output logic      [15:0] compare_a_value,
    output logic      [15:0] compare_b_value,
    output logic             match_a,
    output logic             match_b
);

    // ****************************************
    // State
    // ****************************************
    logic [7:0]  temp_ff,  nxt_temp;
    logic [7:0]  flags_ff, nxt_flags;
    logic [7:0]  mask_ff,  nxt_mask;
    logic [15:0] cap_ff,   nxt_cap;
    logic [15:0] cmpa_ff,  nxt_cmpa;
    logic [15:0] cmpb_ff,  nxt_cmpb;
    logic [15:0] load_ff,  nxt_load;
    logic        ld_ff,    nxt_ld;
    logic        block_ff, nxt_block;
    logic [7:0]  rdata_ff, nxt_rdata;

    logic [7:0]  daddr;
    logic        wr_flags, wr_mask, wr_cnt_lo, wr_cnt_hi;
    logic        wr_cap_lo, wr_cap_hi, wr_a_lo, wr_a_hi, wr_b_lo, wr_b_hi;
    logic        cap_evt;
    logic        set_a, set_b;
    logic [7:0]  set_vec, clr_vec;

    // ****************************************
    // Address decode
    // ****************************************
    // I/O space accesses are lifted into data space
    assign daddr     = cpu_io_space ? 8'(cpu_addr + tcr_pkg::IO_SPACE_DELTA) : cpu_addr;
    assign wr_flags  = cpu_wr && (daddr == tcr_pkg::OFS_EVENT_FLAGS);
    assign wr_mask   = cpu_wr && (daddr == tcr_pkg::OFS_EVENT_MASK);
    assign wr_cnt_lo = cpu_wr && (daddr == tcr_pkg::OFS_COUNT_LOW);
    assign wr_cnt_hi = cpu_wr && (daddr == tcr_pkg::OFS_COUNT_HIGH);
    assign wr_cap_lo = cpu_wr && (daddr == tcr_pkg::OFS_CAPTURE_LOW);
    assign wr_cap_hi = cpu_wr && (daddr == tcr_pkg::OFS_CAPTURE_HIGH);
    assign wr_a_lo   = cpu_wr && (daddr == tcr_pkg::OFS_CMP_A_LOW);
    assign wr_a_hi   = cpu_wr && (daddr == tcr_pkg::OFS_CMP_A_HIGH);
    assign wr_b_lo   = cpu_wr && (daddr == tcr_pkg::OFS_CMP_B_LOW);
    assign wr_b_hi   = cpu_wr && (daddr == tcr_pkg::OFS_CMP_B_HIGH);

    // ****************************************
    // Capture source and TOP selection
    // ****************************************
    // Pin or comparator event; disconnected while capture is TOP
    assign capture_is_top = (waveform_mode_field == tcr_pkg::WGM_PFC_CAP) ||
                            (waveform_mode_field == tcr_pkg::WGM_PC_CAP)  ||
                            (waveform_mode_field == tcr_pkg::WGM_CLR_CAP) ||
                            (waveform_mode_field == tcr_pkg::WGM_FAST_CAP);
    assign cap_evt = !capture_is_top && (capture_src_sel ? comparator_evt : capture_input_pin);

    // ****************************************
    // Compare channels
    // ****************************************
    tcr_compare_unit #(.WIDTH(16)) u_cmp_a (
        .mclk          (mclk),
        .arst_n        (arst_n),
        .tmr_tick      (tmr_tick),
        .count_value   (timer1_count),
        .compare_value (cmpa_ff),
        .block_match   (block_ff),
        .force_strobe  (force_match_a),
        .set_flag      (set_a),
        .match_pulse   (match_a)
    );

    tcr_compare_unit #(.WIDTH(16)) u_cmp_b (
        .mclk          (mclk),
        .arst_n        (arst_n),
        .tmr_tick      (tmr_tick),
        .count_value   (timer1_count),
        .compare_value (cmpb_ff),
        .block_match   (block_ff),
        .force_strobe  (force_match_b),
        .set_flag      (set_b),
        .match_pulse   (match_b)
    );

    // ****************************************
    // Flags and mask
    // ****************************************
    // Hardware set wins over a same-cycle clear
    always_comb begin
        set_vec = 8'h00;
        set_vec[tcr_pkg::BIT_CAPTURE] = capture_is_top ? top_reached : cap_evt;
        set_vec[tcr_pkg::BIT_CMP_B]   = set_b;
        set_vec[tcr_pkg::BIT_CMP_A]   = set_a;
        set_vec[tcr_pkg::BIT_WRAP]    = overflow_evt;
        clr_vec = wr_flags ? cpu_wdata : 8'h00;
        clr_vec[tcr_pkg::BIT_CAPTURE] = clr_vec[tcr_pkg::BIT_CAPTURE] | irq_ack[3];
        clr_vec[tcr_pkg::BIT_CMP_B]   = clr_vec[tcr_pkg::BIT_CMP_B] | irq_ack[2];
        clr_vec[tcr_pkg::BIT_CMP_A]   = clr_vec[tcr_pkg::BIT_CMP_A] | irq_ack[1];
        clr_vec[tcr_pkg::BIT_WRAP]    = clr_vec[tcr_pkg::BIT_WRAP] | irq_ack[0];
        nxt_flags = ((flags_ff & ~clr_vec) | set_vec) & tcr_pkg::FLAG_BITS_MASK;
        nxt_mask  = wr_mask ? (cpu_wdata & tcr_pkg::FLAG_BITS_MASK) : mask_ff;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flags_ff <= tcr_pkg::RST_FLAGS;
            mask_ff  <= tcr_pkg::RST_MASK;
        end else begin
            flags_ff <= nxt_flags;
            mask_ff  <= nxt_mask;
        end
    end

    // Interrupt requests gated by mask and global enable
    assign irq_req[3] = global_irq_en && mask_ff[tcr_pkg::BIT_CAPTURE] && flags_ff[tcr_pkg::BIT_CAPTURE];
    assign irq_req[2] = global_irq_en && mask_ff[tcr_pkg::BIT_CMP_B] && flags_ff[tcr_pkg::BIT_CMP_B];
    assign irq_req[1] = global_irq_en && mask_ff[tcr_pkg::BIT_CMP_A] && flags_ff[tcr_pkg::BIT_CMP_A];
    assign irq_req[0] = global_irq_en && mask_ff[tcr_pkg::BIT_WRAP] && flags_ff[tcr_pkg::BIT_WRAP];

    // ****************************************
    // 16-bit registers and shared temp byte
    // ****************************************
    // High writes park in temp; low access moves both bytes at once
    always_comb begin
        nxt_temp  = temp_ff;
        nxt_cap   = cap_ff;
        nxt_cmpa  = cmpa_ff;
        nxt_cmpb  = cmpb_ff;
        nxt_load  = load_ff;
        nxt_ld    = 1'b0;
        nxt_block = tmr_tick ? 1'b0 : block_ff;
        if (wr_cnt_hi || wr_cap_hi || wr_a_hi || wr_b_hi) begin
            nxt_temp = cpu_wdata;
        end
        if (cpu_rd && daddr == tcr_pkg::OFS_COUNT_LOW) begin
            nxt_temp = timer1_count[15:8];
        end
        if (cpu_rd && daddr == tcr_pkg::OFS_CAPTURE_LOW) begin
            nxt_temp = cap_ff[15:8];
        end
        if (wr_cnt_lo) begin
            nxt_load  = {temp_ff, cpu_wdata};
            nxt_ld    = 1'b1;
            nxt_block = 1'b1;
        end
        if (wr_cap_lo) begin
            nxt_cap = {temp_ff, cpu_wdata};
        end
        if (cap_evt) begin
            nxt_cap = timer1_count;
        end
        if (wr_a_lo) begin
            nxt_cmpa = {temp_ff, cpu_wdata};
        end
        if (wr_b_lo) begin
            nxt_cmpb = {temp_ff, cpu_wdata};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            temp_ff  <= tcr_pkg::RST_BYTE;
            cap_ff   <= tcr_pkg::RST_WORD;
            cmpa_ff  <= tcr_pkg::RST_WORD;
            cmpb_ff  <= tcr_pkg::RST_WORD;
            load_ff  <= tcr_pkg::RST_WORD;
            ld_ff    <= 1'b0;
            block_ff <= 1'b0;
        end else begin
            temp_ff  <= nxt_temp;
            cap_ff   <= nxt_cap;
            cmpa_ff  <= nxt_cmpa;
            cmpb_ff  <= nxt_cmpb;
            load_ff  <= nxt_load;
            ld_ff    <= nxt_ld;
            block_ff <= nxt_block;
        end
    end

    assign capture_value    = cap_ff;
    assign compare_a_value  = cmpa_ff;
    assign compare_b_value  = cmpb_ff;
    assign count_load       = ld_ff;
    assign count_load_value = load_ff;

    // ****************************************
    // Read data
    // ****************************************
    // Low bytes and compare high bytes read live, count and capture high bytes read the temp latch
    always_comb begin
        nxt_rdata = rdata_ff;
        if (cpu_rd) begin
            unique case (daddr)
                tcr_pkg::OFS_EVENT_FLAGS:  nxt_rdata = flags_ff;
                tcr_pkg::OFS_EVENT_MASK:   nxt_rdata = mask_ff;
                tcr_pkg::OFS_COUNT_LOW:    nxt_rdata = timer1_count[7:0];
                tcr_pkg::OFS_CAPTURE_LOW:  nxt_rdata = cap_ff[7:0];
                tcr_pkg::OFS_CMP_A_LOW:    nxt_rdata = cmpa_ff[7:0];
                tcr_pkg::OFS_CMP_A_HIGH:   nxt_rdata = cmpa_ff[15:8];
                tcr_pkg::OFS_CMP_B_LOW:    nxt_rdata = cmpb_ff[7:0];
                tcr_pkg::OFS_CMP_B_HIGH:   nxt_rdata = cmpb_ff[15:8];
                tcr_pkg::OFS_COUNT_HIGH,
                tcr_pkg::OFS_CAPTURE_HIGH: nxt_rdata = temp_ff;
                default:                   nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= tcr_pkg::RST_BYTE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign cpu_rdata = rdata_ff;

    // ****************************************
    // Checks
    // ****************************************
    a_capture_copy: assert property (@(posedge mclk) disable iff (!arst_n)
        cap_evt |=> cap_ff == $past(timer1_count))
        else $error("capture did not copy counter");

    a_capture_top: assert property (@(posedge mclk) disable iff (!arst_n)
        capture_is_top |-> waveform_mode_field[3] && !waveform_mode_field[0])
        else $error("capture used as TOP in wrong mode");

    a_capture_atomic: assert property (@(posedge mclk) disable iff (!arst_n)
        cpu_rd && daddr == tcr_pkg::OFS_CAPTURE_LOW
        |=> temp_ff == $past(cap_ff[15:8]))
        else $error("capture high byte not from temp");

    a_cmp_a_write: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_a_lo |=> cmpa_ff == {$past(temp_ff), $past(cpu_wdata)})
        else $error("compare A write not atomic");

    a_irq_capture: assert property (@(posedge mclk) disable iff (!arst_n)
        irq_req[3] |-> global_irq_en && mask_ff[5] && flags_ff[5])
        else $error("capture request without cause");

    a_irq_cmp_b: assert property (@(posedge mclk) disable iff (!arst_n)
        global_irq_en && mask_ff[2] && flags_ff[2] |-> irq_req[2])
        else $error("compare B request missing");

    a_irq_cmp_a: assert property (@(posedge mclk) disable iff (!arst_n)
        irq_req[1] == (global_irq_en && mask_ff[1] && flags_ff[1]))
        else $error("compare A request wrong");

    a_irq_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
        irq_req[0] == (global_irq_en && mask_ff[0] && flags_ff[0]))
        else $error("overflow request wrong");

    a_capture_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        (capture_is_top ? top_reached : cap_evt) |=> flags_ff[5])
        else $error("capture flag not set");

    a_flag_w1c: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_flags && cpu_wdata[0] && !overflow_evt |=> !flags_ff[0])
        else $error("written one did not clear overflow flag");

    a_flag_ack: assert property (@(posedge mclk) disable iff (!arst_n)
        irq_ack[1] && !set_a |=> !flags_ff[1])
        else $error("vector did not clear compare A flag");

    a_cmp_b_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        set_b |=> flags_ff[2])
        else $error("compare B flag not set");

    a_wrap_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        overflow_evt |=> flags_ff[0])
        else $error("overflow flag not set");

    a_io_alias: assert property (@(posedge mclk) disable iff (!arst_n)
        cpu_rd && cpu_io_space && cpu_addr == 8'h16 |=> cpu_rdata == $past(flags_ff))
        else $error("flags not at I/O alias");

    a_count_load: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_cnt_lo |=> count_load && count_load_value == {$past(temp_ff), $past(cpu_wdata)})
        else $error("counter load not atomic");

    a_count_block: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_cnt_lo |=> block_ff)
        else $error("counter write did not block matches");

endmodule : tcr_regs

// ===== common/tcr_pkg.sv
// Constants shared by the timer capture/compare register block
package tcr_pkg;

    // ****************************************
    // Register offsets in data space
    // ****************************************
    localparam logic [7:0] OFS_EVENT_FLAGS  = 8'h36;
    localparam logic [7:0] OFS_EVENT_MASK   = 8'h6f;
    localparam logic [7:0] OFS_COUNT_LOW    = 8'h84;
    localparam logic [7:0] OFS_COUNT_HIGH   = 8'h85;
    localparam logic [7:0] OFS_CAPTURE_LOW  = 8'h86;
    localparam logic [7:0] OFS_CAPTURE_HIGH = 8'h87;
    localparam logic [7:0] OFS_CMP_A_LOW    = 8'h88;
    localparam logic [7:0] OFS_CMP_A_HIGH   = 8'h89;
    localparam logic [7:0] OFS_CMP_B_LOW    = 8'h8a;
    localparam logic [7:0] OFS_CMP_B_HIGH   = 8'h8b;
    // I/O space address plus this gives the data space address
    localparam logic [7:0] IO_SPACE_DELTA   = 8'h20;

    // ****************************************
    // Field positions in flags and mask
    // ****************************************
    localparam int BIT_CAPTURE = 5;
    localparam int BIT_CMP_B   = 2;
    localparam int BIT_CMP_A   = 1;
    localparam int BIT_WRAP    = 0;
    localparam logic [7:0] FLAG_BITS_MASK = 8'h27;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0]  RST_FLAGS = 8'h00;
    localparam logic [7:0]  RST_MASK  = 8'h00;
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;

    // ****************************************
    // Waveform modes that take TOP from capture
    // ****************************************
    localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WGM_PC_CAP   = 4'ha;
    localparam logic [3:0] WGM_CLR_CAP  = 4'hc;
    localparam logic [3:0] WGM_FAST_CAP = 4'he;

endpackage : tcr_pkg

// ===== verilog/tcr_compare_unit.sv
// One output compare channel: match detection and flag set timing
`timescale 1ns/1ps
module tcr_compare_unit #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // Timer side
    input  wire logic             tmr_tick,
    input  wire logic [WIDTH-1:0] count_value,
    input  wire logic [WIDTH-1:0] compare_value,
    input  wire logic             block_match,
    input  wire logic             force_strobe,
    // Results
    output logic                  set_flag,
    output logic                  match_pulse
);

    logic pend_ff;
    logic nxt_pend;

    // Match seen on a tick is held until the following tick
    always_comb begin
        nxt_pend = pend_ff;
        if (tmr_tick) begin
            nxt_pend = (count_value == compare_value) && !block_match;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // Flag rises one timer clock after the equal count; force only drives the waveform
    assign set_flag    = tmr_tick && pend_ff;
    assign match_pulse = set_flag || force_strobe;

    a_match_pend: assert property (@(posedge mclk) disable iff (!arst_n)
        tmr_tick && (count_value == compare_value) && !block_match |=> pend_ff)
        else $error("equal count not registered as match");

    a_block_match: assert property (@(posedge mclk) disable iff (!arst_n)
        tmr_tick && block_match |=> !pend_ff)
        else $error("match not blocked after count write");

    a_flag_next_tick: assert property (@(posedge mclk) disable iff (!arst_n)
        tmr_tick && pend_ff |-> set_flag)
        else $error("flag not set on tick after match");

    a_force_no_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        force_strobe && !pend_ff |-> !set_flag)
        else $error("forced compare set the flag");

endmodule : tcr_compare_unit

// ===== bench/tcr_cpu_model.sv
// CPU core model issuing byte accesses to the timer register block
`timescale 1ns/1ps
module tcr_cpu_model (
    // Clock
    input  wire logic       mclk,
    // Byte register port
    output logic      [7:0] cpu_addr,
    output logic            cpu_io_space,
    output logic            cpu_wr,
    output logic            cpu_rd,
    output logic      [7:0] cpu_wdata,
    input  wire logic [7:0] cpu_rdata
);
    // Idle port before the first access
    initial begin
        cpu_addr = 8'h00;
        cpu_io_space = 1'b0;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 8'h00;
    end

    // One byte access, strobe held through its taking edge, lines scrambled after
    task automatic acc(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_io_space <= io;
        cpu_wr <= w;
        cpu_rd <= !w;
        cpu_wdata <= d;
        @(posedge mclk);
        cpu_wr <= 1'b0;
        cpu_rd <= 1'b0;
        cpu_addr <= ~a;
        cpu_wdata <= ~d;
        #1;
        q = cpu_rdata;
    endtask : acc

    // Word write: high byte into the shared latch first, low byte commits
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        logic [7:0] q;
        acc(1'b1, 1'b0, a + 8'h01, v[15:8], q);
        acc(1'b1, 1'b0, a, v[7:0], q);
    endtask : wr16
endmodule : tcr_cpu_model

// ===== bench/timer16_capture_compare_regs_tb_top.sv
// Self-checking bench for the timer capture/compare register block
`timescale 1ns/1ps
module timer16_capture_compare_regs_tb_top;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  cpu_addr;
    logic        cpu_io_space;
    logic        cpu_wr;
    logic        cpu_rd;
    logic [7:0]  cpu_wdata;
    logic [7:0]  cpu_rdata;
    logic        global_irq_en = 1'b1;
    logic [3:0]  irq_ack = 4'h0;
    logic [3:0]  irq_req;
    logic [15:0] timer1_count = 16'h0000;
    logic [3:0]  waveform_mode_field = 4'h0;
    logic        capture_src_sel = 1'b0;
    logic [6:0]  evt = 7'h00;
    logic        count_load;
    logic [15:0] count_load_value;
    logic        capture_is_top;
    logic [15:0] capture_value;
    logic [15:0] compare_a_value;
    logic [15:0] compare_b_value;
    logic        match_a;
    logic        match_b;
    logic [1:0]  fm;
    logic [7:0]  q8;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [7:0]  ofs [10] = '{8'h36, 8'h6f, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h90};

    // Clock and hang guard
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end

    tcr_cpu_model cpu_u (.mclk(mclk), .cpu_addr(cpu_addr), .cpu_io_space(cpu_io_space), .cpu_wr(cpu_wr),
                         .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));

    tcr_regs dut_u (.mclk(mclk), .arst_n(arst_n), .cpu_addr(cpu_addr), .cpu_io_space(cpu_io_space),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req), .tmr_tick(evt[6]),
        .timer1_count(timer1_count), .waveform_mode_field(waveform_mode_field), .top_reached(evt[2]),
        .overflow_evt(evt[3]), .count_load(count_load), .count_load_value(count_load_value),
        .capture_is_top(capture_is_top), .capture_input_pin(evt[0]), .comparator_evt(evt[1]),
        .capture_src_sel(capture_src_sel), .force_match_a(evt[4]), .force_match_b(evt[5]),
        .capture_value(capture_value), .compare_a_value(compare_a_value),
        .compare_b_value(compare_b_value), .match_a(match_a), .match_b(match_b));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Byte read compared with the expected value
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        cpu_u.acc(1'b0, 1'b0, a, 8'h00, q);
        check({9'h000, q}, {9'h000, exp});
    endtask : rdchk

    // Byte write in data or I/O space
    task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        cpu_u.acc(1'b1, io, a, d, q);
    endtask : wr

    // One-cycle timer event pulses with a new count, match outputs sampled in that cycle
    task automatic pulse(input logic [6:0] m, input logic [15:0] cnt);
        @(posedge mclk);
        evt <= m;
        timer1_count <= cnt;
        #1;
        fm = {match_b, match_a};
        @(posedge mclk);
        evt <= 7'h00;
    endtask : pulse

    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        foreach (ofs[i]) rdchk(ofs[i], 8'h00);
        cpu_u.wr16(8'h88, 16'h1234);
        check({1'b0, compare_a_value}, 17'h01234);
        cpu_u.wr16(8'h8a, 16'habcd);
        check({1'b0, compare_b_value}, 17'h0abcd);
        rdchk(8'h89, 8'h12);
        wr(1'b0, 8'h6f, 8'hff);
        rdchk(8'h6f, 8'h27);
        // Compare A flag one tick after the match, then interrupt gating and clearing
        pulse(7'h40, 16'h1234);
        pulse(7'h40, 16'h1235);
        check({15'h0, fm}, 17'h1);
        rdchk(8'h36, 8'h02);
        check({13'h0, irq_req}, 17'h2);
        @(posedge mclk) global_irq_en <= 1'b0;
        #1 check({13'h0, irq_req}, 17'h0);
        @(posedge mclk) global_irq_en <= 1'b1;
        wr(1'b0, 8'h36, 8'h00);
        rdchk(8'h36, 8'h02);
        wr(1'b1, 8'h16, 8'h02);
        rdchk(8'h36, 8'h00);
        // Flags read back through the I/O space alias
        cpu_u.acc(1'b0, 1'b1, 8'h16, 8'h00, q8);
        check({9'h000, q8}, 17'h00000);
        // Compare B match, cleared by the vector acknowledge
        pulse(7'h40, 16'habcd);
        pulse(7'h40, 16'h0000);
        check({15'h0, fm}, 17'h2);
        rdchk(8'h36, 8'h04);
        check({13'h0, irq_req}, 17'h4);
        @(posedge mclk) irq_ack <= 4'h4;
        @(posedge mclk) irq_ack <= 4'h0;
        rdchk(8'h36, 8'h00);
        // Forced strobes reach the waveform side but set no flag
        pulse(7'h30, 16'h0000);
        check({15'h0, fm}, 17'h3);
        rdchk(8'h36, 8'h00);
        pulse(7'h08, 16'h0000);
        rdchk(8'h36, 8'h01);
        check({13'h0, irq_req}, 17'h1);
        wr(1'b0, 8'h36, 8'h01);
        // Capture from the pin, then from the comparator
        pulse(7'h01, 16'h5a3c);
        #1 check({1'b0, capture_value}, 17'h05a3c);
        rdchk(8'h36, 8'h20);
        check({13'h0, irq_req}, 17'h8);
        rdchk(8'h86, 8'h3c);
        rdchk(8'h87, 8'h5a);
        wr(1'b0, 8'h36, 8'h20);
        @(posedge mclk) capture_src_sel <= 1'b1;
        pulse(7'h02, 16'h0f0f);
        #1 check({1'b0, capture_value}, 17'h00f0f);
        wr(1'b0, 8'h36, 8'h20);
        // Capture as TOP: flag follows the TOP event
        @(posedge mclk) waveform_mode_field <= 4'hc;
        #1 check({16'h0, capture_is_top}, 17'h1);
        pulse(7'h04, 16'h0f0f);
        rdchk(8'h36, 8'h20);
        @(posedge mclk) waveform_mode_field <= 4'h0;
        wr(1'b0, 8'h36, 8'h20);
        // Counter write loads both bytes and blocks the next tick's match
        cpu_u.wr16(8'h84, 16'h0102);
        check({count_load, count_load_value}, 17'h10102);
        pulse(7'h40, 16'h1234);
        pulse(7'h40, 16'h1235);
        check({15'h0, fm}, 17'h0);
        // Counter read: low byte latches the high byte against later counting
        pulse(7'h00, 16'hbeef);
        rdchk(8'h84, 8'hef);
        pulse(7'h00, 16'h0000);
        rdchk(8'h85, 8'hbe);
        give_verdict();
    end
endmodule : timer16_capture_compare_regs_tb_top
